// file: design/aeom_regs.vh
// Function
// - thermal mask a bit 1 blocks the local temperature limit alert.
// - thermal mask a bits 2..4 block remote channel one..three limit alerts.
// - thermal mask a bits 5..7 block remote diode open or short alerts.
// - a mask bit of one blocks its status bit; zero lets it through.
// - thermal mask a sits at 0x30, bit 0 reserved, read-write, resets to zero.
// - thermal mask b covers overtemp and regulator-hot events, resets to 0xc0.
// - voltage mask a at 0x32 holds eight read-write supply masks.
// - voltage mask b at 0x33, bits 2..0 reserved, bits 3..7 mask voltages.
// - fan mask at 0x34 masks fault status of fans one to eight.
// - digital mask bits 2..0 read-only zero; bits 3..7 masks; resets 0x38.
// - general input mask at 0x36 masks inputs one to eight.
// - event mask a bits 0..3 block general inputs one..four; bit 4 unused.
// - event mask a bit 5 blocks any fan failure from event output a.
// - event mask a bit 6 blocks the overtemp pin from event output a.
// - event mask a bit 7 blocks any voltage violation from event output a.
// - masks ignore the configuration lock; software reset restores defaults.
// - event mask b mirrors mask a layout but gates event output b.
`ifndef AEOM_REGS_VH
`define AEOM_REGS_VH

// =======================================
// register offsets
`define AEOM_ADDR_BASE 8'h30
`define AEOM_ADDR_OVERTEMP_PIN_A 8'h30
`define AEOM_ADDR_OVERTEMP_PIN_B 8'h31
`define AEOM_ADDR_VOLT_A 8'h32
`define AEOM_ADDR_VOLT_B 8'h33
`define AEOM_ADDR_FAN 8'h34
`define AEOM_ADDR_DIGITAL 8'h35
`define AEOM_ADDR_GP 8'h36
`define AEOM_ADDR_EVOUT_A 8'h37
`define AEOM_ADDR_EVOUT_B 8'h38
`define AEOM_NUM_REGS 9
`define AEOM_NUM_ALERT_GROUPS 7
`define AEOM_IDX_NONE 4'hf

// =======================================
// reset values
`define AEOM_RST_OVERTEMP_PIN_A 8'h00
`define AEOM_RST_OVERTEMP_PIN_B 8'hc0
`define AEOM_RST_VOLT_A 8'h00
`define AEOM_RST_VOLT_B 8'h00
`define AEOM_RST_FAN 8'h00
`define AEOM_RST_DIGITAL 8'h38
`define AEOM_RST_GP 8'h00
`define AEOM_RST_EVOUT_A 8'h00
`define AEOM_RST_EVOUT_B 8'h00

// =======================================
// writable bits and status bits that carry a condition
`define AEOM_WMASK_FULL 8'hff
`define AEOM_WMASK_DIGITAL 8'hf8
`define AEOM_VALID_OVERTEMP_PIN_A 8'hfe
`define AEOM_VALID_VOLT_B 8'hf8
`define AEOM_VALID_DIGITAL 8'hf8
`define AEOM_VALID_FULL 8'hff

// =======================================
// event output mask fields
`define AEOM_EV_GP_LSB 0
`define AEOM_EV_GP_MSB 3
`define AEOM_EV_FAN 5
`define AEOM_EV_TEMP 6
`define AEOM_EV_VOLT 7

`endif

// file: design/aeom_alert_gate.v
// =======================================
// masked reduction of one status group
module aeom_alert_gate #(
  parameter [7:0] VALID = 8'hff
) (
  input wire [7:0] status_i,
  input wire [7:0] mask_i,
  output wire hit_o
);
  // reserved positions never reach the alert even if the source drives them
  assign hit_o = |(status_i & ~mask_i & VALID);
endmodule // aeom_alert_gate

// file: design/aeom_event_gate.v
`include "aeom_regs.vh"
// =======================================
// gating of conditions onto one event output
module aeom_event_gate (
  input wire [3:0] gp_i,
  input wire fan_any_i,
  input wire overtemp_i,
  input wire volt_any_i,
  input wire [7:0] mask_i,
  output wire request_o
);
  wire gp_hit;
  wire fan_hit;
  wire temp_hit;
  wire volt_hit;
  // bit 4 is unused and takes no part
  assign gp_hit = |(gp_i & ~mask_i[`AEOM_EV_GP_MSB:`AEOM_EV_GP_LSB]);
  assign fan_hit = fan_any_i & ~mask_i[`AEOM_EV_FAN];
  assign temp_hit = overtemp_i & ~mask_i[`AEOM_EV_TEMP];
  assign volt_hit = volt_any_i & ~mask_i[`AEOM_EV_VOLT];
  assign request_o = gp_hit | fan_hit | temp_hit | volt_hit;
endmodule // aeom_event_gate

// file: design/aeom_top.v
`include "aeom_regs.vh"
// =======================================
// alert and event output mask bank
module aeom_top (
  input wire mclk_i,
  input wire rst_n_i,
  input wire sw_reset_i,
  input wire cfg_lock_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  input wire [7:0] overtemp_pin_status_a_i,
  input wire [7:0] overtemp_pin_status_b_i,
  input wire [7:0] volt_status_a_i,
  input wire [7:0] volt_status_b_i,
  input wire [7:0] fan_status_i,
  input wire [7:0] digital_status_i,
  input wire [7:0] gp_status_i,
  input wire overtemp_pin_i,
  output reg alert_n_o,
  output reg ext_event_out_a_o,
  output reg ext_event_out_b_o
);

  // =======================================
  // decode helpers
  function [3:0] reg_index;
    input [7:0] addr;
    reg [7:0] off;
    begin
      off = addr - `AEOM_ADDR_BASE;
      if (addr >= `AEOM_ADDR_OVERTEMP_PIN_A && addr <= `AEOM_ADDR_EVOUT_B) begin
        reg_index = off[3:0];
      end else begin
        reg_index = `AEOM_IDX_NONE;
      end
    end
  endfunction

  function [7:0] reset_value;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: reset_value = `AEOM_RST_OVERTEMP_PIN_A;
        4'h1: reset_value = `AEOM_RST_OVERTEMP_PIN_B;
        4'h2: reset_value = `AEOM_RST_VOLT_A;
        4'h3: reset_value = `AEOM_RST_VOLT_B;
        4'h4: reset_value = `AEOM_RST_FAN;
        4'h5: reset_value = `AEOM_RST_DIGITAL;
        4'h6: reset_value = `AEOM_RST_GP;
        4'h7: reset_value = `AEOM_RST_EVOUT_A;
        4'h8: reset_value = `AEOM_RST_EVOUT_B;
        default: reset_value = 8'h00;
      endcase
    end
  endfunction

  function [7:0] write_mask;
    input [3:0] idx;
    begin
      case (idx)
        4'h5: write_mask = `AEOM_WMASK_DIGITAL;
        default: write_mask = `AEOM_WMASK_FULL;
      endcase
    end
  endfunction

  // =======================================
  // mask registers
  reg [7:0] mask_q [0:`AEOM_NUM_REGS-1];
  wire [3:0] wr_idx;
  wire [3:0] rd_idx;
  integer i;

  assign wr_idx = reg_index(reg_addr_i);
  assign rd_idx = reg_index(reg_addr_i);

  // lock input deliberately unused: these masks stay writable under lock
  always @(posedge mclk_i) begin
    for (i = 0; i < `AEOM_NUM_REGS; i = i + 1) begin
      if (!rst_n_i || sw_reset_i) begin
        mask_q[i] <= reset_value(i[3:0]);
      end else if (reg_wr_i && wr_idx == i[3:0]) begin
        mask_q[i] <= reg_wdata_i & write_mask(i[3:0]);
      end
    end
  end

  // =======================================
  // register read port
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        // unmapped offsets read zero so a stray poll is harmless
        if (rd_idx == `AEOM_IDX_NONE) begin
          reg_rdata_o <= 8'h00;
        end else begin
          reg_rdata_o <= mask_q[rd_idx];
        end
      end
    end
  end

  // =======================================
  // alert gating
  wire [8*`AEOM_NUM_ALERT_GROUPS-1:0] status_all;
  wire [8*`AEOM_NUM_ALERT_GROUPS-1:0] mask_all;
  wire [`AEOM_NUM_ALERT_GROUPS-1:0] group_hit;
  // constant so that each gate can take its slice as a parameter
  localparam [8*`AEOM_NUM_ALERT_GROUPS-1:0] VALID_ALL = {`AEOM_VALID_FULL, `AEOM_VALID_DIGITAL, `AEOM_VALID_FULL,
                                                         `AEOM_VALID_VOLT_B, `AEOM_VALID_FULL, `AEOM_VALID_FULL,
                                                         `AEOM_VALID_OVERTEMP_PIN_A};

  assign status_all = {gp_status_i, digital_status_i, fan_status_i, volt_status_b_i,
                       volt_status_a_i, overtemp_pin_status_b_i, overtemp_pin_status_a_i};
  assign mask_all = {mask_q[6], mask_q[5], mask_q[4], mask_q[3], mask_q[2], mask_q[1], mask_q[0]};

  genvar g;
  generate
    for (g = 0; g < `AEOM_NUM_ALERT_GROUPS; g = g + 1) begin : g_alert
      aeom_alert_gate #(
        .VALID(VALID_ALL[8*g+7:8*g])
      ) u_gate (
        .status_i(status_all[8*g+7:8*g]),
        .mask_i(mask_all[8*g+7:8*g]),
        .hit_o(group_hit[g])
      );
    end
  endgenerate

  // =======================================
  // event output gating
  wire fan_any;
  wire volt_any;
  wire [1:0] event_req;

  assign fan_any = |fan_status_i;
  assign volt_any = |volt_status_a_i | |(volt_status_b_i & `AEOM_VALID_VOLT_B);

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_event
      aeom_event_gate u_event (
        .gp_i(gp_status_i[3:0]),
        .fan_any_i(fan_any),
        .overtemp_i(overtemp_pin_i),
        .volt_any_i(volt_any),
        .mask_i(mask_q[7+g]),
        .request_o(event_req[g])
      );
    end
  endgenerate

  // =======================================
  // registered outputs
  // one cycle of latency traded for glitch-free pins
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      alert_n_o <= 1'b1;
      ext_event_out_a_o <= 1'b0;
      ext_event_out_b_o <= 1'b0;
    end else begin
      alert_n_o <= ~(|group_hit);
      ext_event_out_a_o <= event_req[0];
      ext_event_out_b_o <= event_req[1];
    end
  end

endmodule // aeom_top

// file: bench/aeom_top_checker.sv
// =======================================
// port checks
module aeom_chk (
  input logic mclk_i,
  input logic rst_n_i,
  input logic [7:0] reg_addr_i,
  input logic reg_rd_i,
  input logic [7:0] reg_rdata_o,
  input logic reg_rvalid_o,
  input logic [7:0] overtemp_pin_status_a_i,
  input logic [7:0] overtemp_pin_status_b_i,
  input logic [7:0] volt_status_a_i,
  input logic [7:0] volt_status_b_i,
  input logic [7:0] fan_status_i,
  input logic [7:0] digital_status_i,
  input logic [7:0] gp_status_i,
  input logic overtemp_pin_i,
  input logic alert_n_o,
  input logic ext_event_out_a_o,
  input logic ext_event_out_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // reserved status positions left out on purpose
  wire quiet = ~|{overtemp_pin_status_a_i[7:1], overtemp_pin_status_b_i, volt_status_a_i, volt_status_b_i[7:3],
    fan_status_i, digital_status_i[7:3], gp_status_i};
  wire calm = ~|{gp_status_i[3:0], fan_status_i, overtemp_pin_i, volt_status_a_i, volt_status_b_i[7:3]};
  wire unmap = reg_addr_i < 8'h30 || reg_addr_i > 8'h38;
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
  a_valid_pulse: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray rvalid");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
  a_unmapped_zero: assert property (reg_rd_i && unmap |=> reg_rdata_o == 8'h00) else $error("unmapped");
  a_digital_low: assert property (reg_rd_i && reg_addr_i == 8'h35 |=> reg_rdata_o[2:0] == 3'h0)
    else $error("digital low bits");
  a_alert_release: assert property (quiet [*2] |=> alert_n_o) else $error("alert held");
  a_event_a_idle: assert property (calm [*2] |=> !ext_event_out_a_o) else $error("event a held");
  a_event_b_idle: assert property (calm [*2] |=> !ext_event_out_b_o) else $error("event b held");
  cover property (!alert_n_o);
  cover property (ext_event_out_b_o && !ext_event_out_a_o);
  cover property (reg_rvalid_o && reg_rdata_o == 8'hff);
endmodule // aeom_chk

bind aeom_top aeom_chk u_chk (.mclk_i, .rst_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
  .overtemp_pin_status_a_i, .overtemp_pin_status_b_i, .volt_status_a_i, .volt_status_b_i, .fan_status_i,
  .digital_status_i, .gp_status_i, .overtemp_pin_i, .alert_n_o, .ext_event_out_a_o, .ext_event_out_b_o);

// file: bench/aeom_top_tb.sv
// =======================================
// mask bank bench
module aeom_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, rst_n_i = 0, sw = 0, lock = 0, wr = 0, rd = 0, ot = 0, rvalid, alert_n, ev_a, ev_b;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [7:0] st [7] = '{default: 8'h00};
  logic [7:0] rst_v [9] = '{8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h38, 8'h00, 8'h00, 8'h00};
  logic [7:0] ok_v [7] = '{8'hfe, 8'hff, 8'hff, 8'hf8, 8'hff, 8'hf8, 8'hff};
  int failures = 0, checks = 0, cyc = 0;
  aeom_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sw_reset_i(sw), .cfg_lock_i(lock),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .overtemp_pin_status_a_i(st[0]), .overtemp_pin_status_b_i(st[1]), .volt_status_a_i(st[2]),
    .volt_status_b_i(st[3]), .fan_status_i(st[4]), .digital_status_i(st[5]), .gp_status_i(st[6]),
    .overtemp_pin_i(ot), .alert_n_o(alert_n), .ext_event_out_a_o(ev_a), .ext_event_out_b_o(ev_b));
  always #5 mclk_i = ~mclk_i;
  // whole run is under a thousand cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task idle(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task wr_r(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge mclk_i);
    wr <= 0;
  endtask
  task rd_r(logic [7:0] a, logic [7:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1;
    @(posedge mclk_i);
    rd <= 0;
    // rvalid stands for this one cycle only
    #1;
    chk("rvalid", 8'h01, {7'h0, rvalid});
    chk("rdata", e, rdata);
    @(posedge mclk_i);
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1;
    for (int i = 0; i < 9; i++) rd_r(8'(8'h30 + i), rst_v[i]);
    lock <= 1;
    for (int i = 0; i < 10; i++) wr_r(8'(8'h30 + i), 8'hff);
    for (int i = 0; i < 10; i++) rd_r(8'(8'h30 + i), i == 5 ? 8'hf8 : i == 9 ? 8'h00 : 8'hff);
    @(posedge mclk_i);
    sw <= 1;
    @(posedge mclk_i);
    sw <= 0;
    for (int i = 0; i < 9; i++) rd_r(8'(8'h30 + i), rst_v[i]);
    for (int i = 0; i < 9; i++) wr_r(8'(8'h30 + i), 8'h00);
    // every status bit of every group, open then masked
    for (int g = 0; g < 7; g++) begin
      for (int b = 0; b < 8; b++) begin
        st[g] <= 8'h01 << b;
        idle(3);
        chk("alert_n", {7'h0, ~ok_v[g][b]}, {7'h0, alert_n});
        wr_r(8'(8'h30 + g), 8'h01 << b);
        idle(3);
        chk("alert_n", 8'h01, {7'h0, alert_n});
        @(posedge mclk_i);
        st[g] <= 8'h00;
        wr_r(8'(8'h30 + g), 8'h00);
      end
    end
    // bit 4 of the event masks gates nothing, so it is skipped
    for (int i = 0; i < 8; i++) begin
      if (i != 4) begin
        if (i < 4) st[6] <= 8'h01 << i;
        else if (i == 5) st[4] <= 8'h20;
        else if (i == 6) ot <= 1;
        else st[3] <= 8'h80;
        idle(3);
        chk("events", 8'h03, {6'h0, ev_a, ev_b});
        wr_r(8'h37, 8'h01 << i);
        idle(3);
        chk("events", 8'h01, {6'h0, ev_a, ev_b});
        wr_r(8'h38, 8'h01 << i);
        idle(3);
        chk("events", 8'h00, {6'h0, ev_a, ev_b});
        @(posedge mclk_i);
        st <= '{default: 8'h00};
        ot <= 0;
        wr_r(8'h37, 8'h00);
        wr_r(8'h38, 8'h00);
      end
    end
    end_of_test;
  end
endmodule // aeom_top_tb
